// ---- logic/sram_port_pkg.sv ----
package sram_port_pkg;

    // bus geometry: four byte lanes of eight data bits plus one parity bit
    localparam int ADDR_W = 20;
    localparam int LANES  = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;
    localparam int BURST_W = 2;

    // values after reset
    localparam logic [ADDR_W-1:0]  ADDR_RST  = 20'h00000;
    localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
    localparam logic [DATA_W-1:0]  DATA_RST  = 36'h0_0000_0000;
    localparam logic [LANES-1:0]   LANE_NONE = 4'h0;
    localparam logic [LANES-1:0]   LANE_ALL  = 4'hF;
    localparam logic               MODE_RST  = 1'b1;

    // synchroniser depth for the sleep and strap pins, which are not tied to the bus clock
    localparam int SYNC_STAGES = 2;

    // burst order selected by the strap
    typedef enum logic {
        ORDER_LINEAR,
        ORDER_INTERLEAVED
    } burst_order_t;

    // request handed to the storage core in each cycle
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0]  lane_we;
        logic [DATA_W-1:0] wdata;
    } core_req_t;

endpackage

// ---- logic/sync_sram_bus_port.sv ----
`timescale 1ns/1ps
module sync_sram_bus_port
    import sram_port_pkg::*;
#(
    parameter bit NO_THIRD_ENABLE = 1'b0
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    // address and strobes
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              processor_addr_strobe_n,
    input  wire logic              controller_addr_strobe_n,
    input  wire logic              burst_advance_n,
    // chip enables
    input  wire logic              chip_sel_first_n,
    input  wire logic              chip_sel_second,
    input  wire logic              chip_sel_third_n,
    // write controls
    input  wire logic              global_write_n,
    input  wire logic              byte_write_qualify_n,
    input  wire logic [LANES-1:0]  byte_lane_write_sel_n,
    // asynchronous controls and strap
    input  wire logic              output_enable_n,
    input  wire logic              sleep_request,
    input  wire logic              burst_mode_strap,
    // data and parity pins, split
    input  wire logic [DATA_W-1:0] data_io_in,
    output logic      [DATA_W-1:0] data_io_out,
    output logic                   data_io_oe,
    // storage core
    output core_req_t              core_req,
    input  wire logic [DATA_W-1:0] core_rdata,
    // status
    output logic                   sleeping
);

    logic [1:0]         rst_pipe_reg;
    logic               rst_ok;
    logic [SYNC_STAGES-1:0] sleep_pipe_reg;
    logic [SYNC_STAGES-1:0] mode_pipe_reg;
    logic               sleep_sync;
    burst_order_t       order_reg;
    logic               strap_done_reg;

    logic [ADDR_W-1:0]  addr_reg;
    logic [BURST_W-1:0] start_reg;
    logic [BURST_W-1:0] count_reg;
    logic               sel_reg;
    logic [LANES-1:0]   lane_we_reg;
    logic [DATA_W-1:0]  din_reg;
    logic [DATA_W-1:0]  dout_reg;
    logic               pend_reg;
    logic               drive_reg;
    logic               hold_reg;

    logic               cs_ok;
    logic               proc_take;
    logic               load;
    logic               sel_next;
    logic               write_cmd;
    logic [LANES-1:0]   lane_next;
    logic               read_op;
    logic [BURST_W-1:0] burst_low;

    // burst address from start and step count
    function automatic logic [BURST_W-1:0] burst_addr(
        input burst_order_t         order,
        input logic [BURST_W-1:0]   start,
        input logic [BURST_W-1:0]   count
    );
        if (order == ORDER_LINEAR) begin
            burst_addr = start + count;
        end else begin
            burst_addr = start ^ count;
        end
    endfunction

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_pipe_reg <= 2'h0;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end
    assign rst_ok = rst_pipe_reg[1];

    // sleep and strap come from pins off the bus clock; reset by the pin reset (sleep to 0, strap to MODE_RST)
    // so both flops already hold the strap when rst_ok rises, not a reset value
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sleep_pipe_reg <= '0;
            mode_pipe_reg  <= {SYNC_STAGES{MODE_RST}};
        end else begin
            sleep_pipe_reg <= {sleep_pipe_reg[0], sleep_request};
            mode_pipe_reg  <= {mode_pipe_reg[0], burst_mode_strap};
        end
    end
    assign sleep_sync = sleep_pipe_reg[SYNC_STAGES-1];
    assign sleeping   = sleep_sync;

    // strap caught once after release; it must stay static anyway
    always_ff @(posedge clk_sys or negedge rst_ok) begin
        if (!rst_ok) begin
            order_reg      <= burst_order_t'(MODE_RST);
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            order_reg      <= mode_pipe_reg[SYNC_STAGES-1] ? ORDER_INTERLEAVED
                                                          : ORDER_LINEAR;
            strap_done_reg <= 1'b1;
        end
    end

    // decode of the sampled bus controls
    always_comb begin
        cs_ok     = !chip_sel_first_n && chip_sel_second
                    && (!chip_sel_third_n || NO_THIRD_ENABLE);
        proc_take = !processor_addr_strobe_n && !chip_sel_first_n;
        load      = proc_take || !controller_addr_strobe_n;
        sel_next  = load ? cs_ok : sel_reg;
        write_cmd = !global_write_n || !byte_write_qualify_n;
        if (!global_write_n) begin
            lane_next = LANE_ALL;
        end else if (!byte_write_qualify_n) begin
            lane_next = ~byte_lane_write_sel_n;
        end else begin
            lane_next = LANE_NONE;
        end
        // a processor-strobe cycle is always a read; its write follows later
        read_op   = sel_next && (proc_take || !write_cmd);
    end

    // address register and burst counter
    always_ff @(posedge clk_sys or negedge rst_ok) begin
        if (!rst_ok) begin
            addr_reg  <= ADDR_RST;
            start_reg <= BURST_RST;
            count_reg <= BURST_RST;
        end else if (!sleep_sync) begin
            if (load && cs_ok) begin
                addr_reg  <= addr;
                start_reg <= addr[BURST_W-1:0];
                count_reg <= BURST_RST;
            end else if (!load && sel_reg && !burst_advance_n) begin
                count_reg <= count_reg + 2'h1;
            end
        end
    end

    // selection state, latched only when a new address is loaded
    always_ff @(posedge clk_sys or negedge rst_ok) begin
        if (!rst_ok) begin
            sel_reg <= 1'b0;
        end else if (!sleep_sync) begin
            sel_reg <= sel_next;
        end
    end

    // write lanes and input data register; core writes one cycle later
    always_ff @(posedge clk_sys or negedge rst_ok) begin
        if (!rst_ok) begin
            lane_we_reg <= LANE_NONE;
            din_reg     <= DATA_RST;
        end else if (sleep_sync) begin
            lane_we_reg <= LANE_NONE;
        end else begin
            din_reg     <= data_io_in;
            lane_we_reg <= (sel_next && !proc_take) ? lane_next : LANE_NONE;
        end
    end

    assign burst_low = burst_addr(order_reg, start_reg, count_reg);

    // request to the storage core
    always_comb begin
        core_req.addr    = {addr_reg[ADDR_W-1:BURST_W], burst_low};
        core_req.lane_we = lane_we_reg;
        core_req.wdata   = din_reg;
    end

    // output register: data of the address sampled one edge earlier
    always_ff @(posedge clk_sys or negedge rst_ok) begin
        if (!rst_ok) begin
            dout_reg <= DATA_RST;
        end else if (!sleep_sync) begin
            dout_reg <= core_rdata;
        end
    end

    // driver enable pipeline: masks first read after deselect, holds one after
    // read data shows one edge after the read is taken, so the enable lags a stage
    always_ff @(posedge clk_sys or negedge rst_ok) begin
        if (!rst_ok) begin
            pend_reg  <= 1'b0;
            drive_reg <= 1'b0;
            hold_reg  <= 1'b0;
        end else if (sleep_sync) begin
            pend_reg  <= 1'b0;
            drive_reg <= 1'b0;
            hold_reg  <= 1'b0;
        end else begin
            pend_reg  <= read_op && sel_reg;
            drive_reg <= pend_reg;
            hold_reg  <= drive_reg && !sel_reg;
        end
    end

    // output enable acts without the clock so the bus can turn quickly
    assign data_io_out = dout_reg;
    assign data_io_oe  = (drive_reg || hold_reg) && !output_enable_n && !sleep_sync;

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_ok);

    addr_capture_a: assert property (load && cs_ok && !sleep_sync |=> addr_reg == $past(addr))
        else $error("address not captured on accepted strobe");
    burst_load_a: assert property (load && cs_ok && !sleep_sync
        |=> count_reg == 2'h0 && start_reg == $past(addr[1:0]))
        else $error("burst counter not loaded from low address bits");
    burst_step_a: assert property (!load && sel_reg && !burst_advance_n && !sleep_sync
        |=> count_reg == $past(count_reg) + 2'h1)
        else $error("burst counter did not advance");
    global_write_a: assert property (!global_write_n && sel_next && !proc_take && !sleep_sync
        |=> core_req.lane_we == LANE_ALL)
        else $error("global write missed a lane");
    byte_qualify_a: assert property (global_write_n && byte_write_qualify_n
        |=> core_req.lane_we == LANE_NONE)
        else $error("lane written without qualifier");
    proc_ignore_a: assert property (chip_sel_first_n && controller_addr_strobe_n
        |=> $stable(addr_reg) && $stable(sel_reg))
        else $error("processor strobe acted with first enable high");
    strobe_prio_a: assert property (!processor_addr_strobe_n && !controller_addr_strobe_n
        && !chip_sel_first_n |=> core_req.lane_we == LANE_NONE)
        else $error("controller strobe write acted beside processor strobe");
    read_latency_a: assert property (!sleep_sync ##1 !sleep_sync
        |-> dout_reg == $past(core_rdata))
        else $error("read data not one cycle behind address");
    first_mask_a: assert property (read_op && !sel_reg && !sleep_sync |-> ##2 !drive_reg)
        else $error("driver on in first read cycle after deselect");
    dcd_hold_a: assert property (drive_reg && !sel_reg && !sleep_sync
        |=> hold_reg ##1 !hold_reg)
        else $error("drivers not held exactly one cycle after deselect");
    hold_once_a: assert property (hold_reg |=> !hold_reg)
        else $error("extra driver cycle lasted more than one clock");

    // read pipeline stages line up with the data register
    pend_track_a: assert property (read_op && sel_reg && !sleep_sync
        |=> pend_reg)
        else $error("selected read did not enter the pipeline");
    data_cycle_a: assert property (pend_reg && !sleep_sync
        |=> drive_reg)
        else $error("driver not on in the data cycle of a read");

    // selection is decided only at an address load
    sel_hold_a: assert property (!load |=> $stable(sel_reg))
        else $error("selection changed without an address load");
    sel_load_a: assert property (load && !sleep_sync
        |=> sel_reg == $past(cs_ok))
        else $error("selection not latched at address load");
    select_rule_a: assert property (load && !sleep_sync && (chip_sel_first_n || !chip_sel_second)
        |=> !sel_reg)
        else $error("selected with first or second enable inactive");
    select_ok_a: assert property (load && !sleep_sync && !chip_sel_first_n && chip_sel_second
        && (!chip_sel_third_n || NO_THIRD_ENABLE) |=> sel_reg)
        else $error("not selected with all enables active");
    ctrl_desel_a: assert property (!controller_addr_strobe_n && chip_sel_first_n && !sleep_sync
        |=> !sel_reg)
        else $error("controller strobe selected with first enable high");
    desel_write_a: assert property (load && !cs_ok && !sleep_sync
        |=> core_req.lane_we == LANE_NONE)
        else $error("write accepted at a deselecting load");

    // data capture, burst origin and strap
    din_capture_a: assert property (!sleep_sync |=> core_req.wdata == $past(data_io_in))
        else $error("input data register missed the pins");
    burst_start_a: assert property (count_reg == 2'h0 |-> core_req.addr[BURST_W-1:0] == start_reg)
        else $error("burst does not begin at the loaded address");
    count_hold_a: assert property (!load && (!sel_reg || burst_advance_n)
        |=> $stable(count_reg))
        else $error("burst counter moved without advance");
    strap_order_a: assert property ($rose(strap_done_reg)
        |-> order_reg == burst_order_t'($past(mode_pipe_reg[SYNC_STAGES-1])))
        else $error("burst order does not follow the strap");

    // driver enable against the asynchronous output enable and sleep
    drive_off_a: assert property (!drive_reg && !hold_reg |-> !data_io_oe)
        else $error("pins driven with no read data to show");
    oe_follow_a: assert property ((drive_reg || hold_reg) && !output_enable_n && !sleep_sync
        |-> data_io_oe)
        else $error("pins not driven with output enable low");
    sleep_nowrite_a: assert property (sleep_sync |=> core_req.lane_we == LANE_NONE)
        else $error("write issued while asleep");

    // two checks per byte lane; the global write overrides every select,
    // so only cycles with global write high say anything about a lane
    generate
        for (genvar k = 0; k < LANES; k++) begin : g_lane_chk
            lane_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_ok)
                global_write_n && byte_lane_write_sel_n[k] |=> !core_req.lane_we[k])
                else $error("byte lane written without its select");
            lane_pick_a: assert property (@(posedge clk_sys) disable iff (!rst_ok)
                global_write_n && !byte_write_qualify_n && !byte_lane_write_sel_n[k]
                && sel_next && !proc_take && !sleep_sync |=> core_req.lane_we[k])
                else $error("selected byte lane not written");
        end
    endgenerate
    oe_gate_a: assert property (output_enable_n |-> !data_io_oe)
        else $error("pins driven while output enable high");
    sleep_freeze_a: assert property (sleep_sync |=> $stable(addr_reg) && $stable(count_reg)
        && !data_io_oe)
        else $error("activity during sleep");

    read_burst_c: cover property (read_op && sel_reg ##1 !burst_advance_n [*3]);
    byte_write_c: cover property (core_req.lane_we != LANE_NONE && core_req.lane_we != LANE_ALL);
    deselect_c: cover property (hold_reg && !drive_reg);
    sleep_c: cover property ($rose(sleep_sync));
    linear_c: cover property (order_reg == ORDER_LINEAR && count_reg == 2'h3);

endmodule

// ---- tb/sram_core_model.sv ----
`timescale 1ns/1ps
// storage core behind the port: combinational read, lane writes on the clock
module sram_core_model
    import sram_port_pkg::*;
(
    // clock
    input  wire logic              clk_sys,
    // request from the port and read data back
    input  wire core_req_t         core_req,
    output logic      [DATA_W-1:0] core_rdata
);
    // small array, upper address bits alias; enough for the scenarios
    // cleared at start so reads of unwritten words give known data
    logic [DATA_W-1:0] mem [64] = '{default: '0};

    assign core_rdata = mem[core_req.addr[5:0]];

    // each lane written only under its own enable
    always_ff @(posedge clk_sys) begin
        for (int k = 0; k < LANES; k++) begin
            if (core_req.lane_we[k]) begin
                mem[core_req.addr[5:0]][k*LANE_W +: LANE_W] <= core_req.wdata[k*LANE_W +: LANE_W];
            end
        end
    end
endmodule

// ---- tb/tb_sync_sram_bus_port.sv ----
`timescale 1ns/1ps
module tb_sync_sram_bus_port
    import sram_port_pkg::*;
;
    localparam logic [DATA_W-1:0] D1 = 36'h1_2345_6789;
    localparam logic [DATA_W-1:0] D2 = 36'hA_BCDE_F012;
    localparam logic [DATA_W-1:0] M2 = 36'h0_07FC_01FF;
    localparam logic [DATA_W-1:0] E5 = (D2 & M2) | (D1 & ~M2);

    // pins, all given a value at time zero
    logic              clk_sys = 1'b0;
    logic              rstn    = 1'b0;
    logic              ps_n    = 1'b1;
    logic              cs_n    = 1'b1;
    logic              step_n  = 1'b1;
    logic              sel1_n  = 1'b0;
    logic              sel2    = 1'b1;
    logic              sel3_n  = 1'b0;
    logic              glob_n  = 1'b1;
    logic              qual_n  = 1'b1;
    logic [LANES-1:0]  lane_n  = 4'hF;
    logic              oe_n    = 1'b0;
    logic              sleep   = 1'b0;
    logic              strap   = 1'b1;
    logic [ADDR_W-1:0] a       = 20'h00000;
    logic [DATA_W-1:0] pin_drv = 36'h0_0000_0000;
    logic [DATA_W-1:0] din, dout, rdata;
    logic              oe, sleeping;
    core_req_t         req;
    int                mismatches  = 0;
    int                comparisons = 0;

    always #4 clk_sys = ~clk_sys;

    // wire level: the port wins while it drives, else the bench's value
    assign din = oe ? dout : pin_drv;

    sync_sram_bus_port uut (.clk_sys(clk_sys), .rstn(rstn), .addr(a), .processor_addr_strobe_n(ps_n),
        .controller_addr_strobe_n(cs_n), .burst_advance_n(step_n), .chip_sel_first_n(sel1_n),
        .chip_sel_second(sel2), .chip_sel_third_n(sel3_n), .global_write_n(glob_n),
        .byte_write_qualify_n(qual_n), .byte_lane_write_sel_n(lane_n), .output_enable_n(oe_n),
        .sleep_request(sleep), .burst_mode_strap(strap), .data_io_in(din), .data_io_out(dout),
        .data_io_oe(oe), .core_req(req), .core_rdata(rdata), .sleeping(sleeping));
    sram_core_model core (.clk_sys(clk_sys), .core_req(req), .core_rdata(rdata));

    task automatic complete_run;
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // guard against a hang
    initial begin
        #400000;
        mismatches++;
        complete_run;
    end

    task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one bus cycle: pins set after a falling edge, taken by the next rising edge
    task automatic drive(input logic p, c, s, e1, e2, g, q, input logic [3:0] l,
                         input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
        {ps_n, cs_n, step_n, sel1_n, sel2, glob_n, qual_n} = {p, c, s, e1, e2, g, q};
        lane_n = l;
        a = ad;
        pin_drv = d;
        @(negedge clk_sys);
    endtask

    // released data lines show the inverse, never a stale copy
    task automatic idle;
        drive(1, 1, 1, 0, 1, 1, 1, 4'hF, a, ~pin_drv);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] ad);
        drive(0, 1, 1, 0, 1, 1, 1, 4'hF, ad, ~pin_drv);
    endtask

    task automatic do_reset(input logic st);
        rstn = 1'b0;
        strap = st;
        repeat (2) @(negedge clk_sys);
        chk_flag(oe, 1'b0);
        chk_val(req, '0);
        chk_flag(sleeping, 1'b0);
        rstn = 1'b1;
        repeat (6) @(negedge clk_sys);
    endtask

    task automatic t_write;
        drive(1, 0, 1, 0, 1, 0, 1, 4'hF, 20'h00005, D1);
        chk_val(req.lane_we, LANE_ALL);
        chk_val(req.wdata, D1);
        drive(1, 0, 1, 0, 1, 1, 0, 4'hA, 20'h00005, D2);
        chk_val(req.lane_we, 4'h5);
        drive(1, 0, 1, 0, 1, 1, 1, 4'h0, 20'h00005, ~D2);
        chk_val(req.lane_we, LANE_NONE);
    endtask

    task automatic t_read;
        drive(1, 0, 1, 0, 0, 1, 1, 4'hF, 20'h00009, ~pin_drv);
        chk_val(dout, E5);
        chk_flag(oe, 1'b1);
        idle;
        chk_flag(oe, 1'b1);
        idle;
        chk_flag(oe, 1'b0);
        rd(20'h00005);
        idle;
        chk_flag(oe, 1'b0);
        rd(20'h00005);
        oe_n = 1'b1;
        idle;
        chk_flag(oe, 1'b0);
        chk_val(dout, E5);
        oe_n = 1'b0;
        #1;
        chk_flag(oe, 1'b1);
    endtask

    task automatic t_refuse;
        drive(0, 1, 1, 1, 1, 1, 1, 4'hF, 20'h00009, ~pin_drv);
        chk_val(req.addr, 20'h00005);
        drive(1, 0, 1, 0, 0, 0, 1, 4'hF, 20'h00009, D1);
        chk_val(req.lane_we, LANE_NONE);
        drive(0, 0, 1, 0, 1, 0, 1, 4'hF, 20'h00006, D1);
        chk_val(req.lane_we, LANE_NONE);
        chk_val(req.addr, 20'h00006);
    endtask

    // enables wrong during advance: selection must come from the load
    task automatic t_burst(input burst_order_t ord);
        logic [1:0] lo;
        rd(20'h00011);
        for (int i = 0; i < 5; i++) begin
            lo = (ord == ORDER_LINEAR) ? 2'(1 + i) : 2'(1 ^ i);
            chk_val(req.addr, {18'h00004, lo});
            if (i >= 2) begin
                chk_flag(oe, 1'b1);
            end
            drive(1, 1, 0, 0, 0, 1, 1, 4'hF, 20'h0000C, ~pin_drv);
        end
        idle;
    endtask

    task automatic t_sleep;
        sleep = 1'b1;
        repeat (4) idle;
        chk_flag(sleeping, 1'b1);
        drive(1, 0, 1, 0, 1, 0, 1, 4'hF, 20'h00005, D1);
        chk_val(req.lane_we, LANE_NONE);
        chk_flag(oe, 1'b0);
        sleep = 1'b0;
        repeat (4) idle;
        chk_flag(sleeping, 1'b0);
        rd(20'h00005);
        idle;
        chk_val(dout, E5);
    endtask

    // main sequence; second reset brings the strap low for linear order
    initial begin
        do_reset(1'b1);
        t_write;
        t_read;
        t_refuse;
        t_burst(ORDER_INTERLEAVED);
        t_sleep;
        do_reset(1'b0);
        t_burst(ORDER_LINEAR);
        complete_run;
    end
endmodule
